// ==== include/acc_params.svh ====
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// Register offsets on the host port.
`define ACC_OFF_CH2_OCAL_LOW   6'h15
`define ACC_OFF_CH2_GCAL_HIGH  6'h16
`define ACC_OFF_CH2_GCAL_LOW   6'h17
`define ACC_OFF_CH3_CONFIG     6'h18
`define ACC_OFF_CH3_OCAL_HIGH  6'h19
`define ACC_OFF_CH3_OCAL_LOW   6'h1A
`define ACC_OFF_CH2_OCAL_HIGH  6'h14
`define ACC_OFF_APPLY_STATUS   6'h3F

// Reset values.
`define ACC_RST_ZERO           16'h0000
`define ACC_RST_GAIN_HIGH      16'h8000

// Field positions.
`define ACC_LOW_FIELD_MSB      15
`define ACC_LOW_FIELD_LSB      8
`define ACC_PHASE_MSB          15
`define ACC_PHASE_LSB          6
`define ACC_DCOFF_BIT          2
`define ACC_MUX_MSB            1
`define ACC_MUX_LSB            0

`endif

// ==== include/acc_pkg.sv ====
package acc_pkg;
    // Input routing choices for channel 3.
    typedef enum logic [1:0] {
        ACC_IN_NORMAL  = 2'h0,
        ACC_IN_SHORTED = 2'h1,
        ACC_IN_TEST_POS = 2'h2,
        ACC_IN_TEST_NEG = 2'h3
    } acc_input_sel_t;

    // Applied correction set for the datapath.
    typedef struct packed {
        logic [23:0] chan2_offset;
        logic [23:0] chan2_gain;
        logic [23:0] chan3_offset;
        logic [9:0]  chan3_phase;
        logic        chan3_dc_off;
        logic [1:0]  chan3_mux;
    } acc_cal_set_t;
endpackage : acc_pkg

// ==== include/acc_reg_if.sv ====
// Register write path shared between the bank and its word-register leaves.
interface acc_reg_if;
    logic [5:0]  address;
    logic [15:0] write_data;
    logic        write_strobe;

    modport bank (output address, output write_data, output write_strobe);
    modport leaf (input address, input write_data, input write_strobe);
endinterface : acc_reg_if

// ==== logic/acc_cal_regs.sv ====
`include "acc_params.svh"

// Operation
// - Channel 2 offset bits 7:0 live in bits 15:8 of the channel 2 offset low register.
// - Low bytes of calibration low registers and config bits 5:3 are read-only zero.
// - Channel 2 gain bits 23:8 fill the gain high register, which resets to 8000h for unity gain.
// - Each 24-bit gain is unsigned, spanning zero to just under 2.0 in steps of 2^-23... scaled as 1.23 fixed point.
// - Channel 2 gain bits 7:0 sit in bits 15:8 of the gain low register, reset zero.
// - Channel 3 phase delay is a ten-bit signed count in config bits 15:6, reset zero.
// - Config bit 2 low defers to the global DC filter setting, high turns the filter off for channel 3.
// - Config bits 1:0 pick normal pins, shorted inputs, positive test or negative test for channel 3.
// - Channel 3 offset bits 23:8 fill the offset high register, reset zero.
module acc_cal_regs
    import acc_pkg::*;
(
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        reset,
    // Host register port.
    input  wire logic [5:0]  reg_address,
    input  wire logic [15:0] reg_write_data,
    input  wire logic        reg_write_strobe,
    input  wire logic        reg_read_strobe,
    output logic [15:0]      reg_read_data,
    // Datapath timing and global setting.
    input  wire logic        conversion_boundary,
    input  wire logic        global_dc_filter_setting,
    // Applied channel 2 corrections.
    output logic [23:0]      chan2_offset_trim,
    output logic [23:0]      chan2_gain_trim,
    // Applied channel 3 settings.
    output logic [23:0]      chan3_offset_trim,
    output logic [9:0]       chan3_phase_delay,
    output logic             chan3_dc_filter_enable,
    output logic             chan3_short_inputs,
    output logic             chan3_connect_pins,
    output logic             chan3_test_positive,
    output logic             chan3_test_negative,
    // Pending-update flag.
    output logic             update_pending
);
    localparam logic [15:0] LOW_MASK = 16'hFF00;
    localparam logic [15:0] CFG_MASK = 16'hFFC7;
    localparam logic [15:0] ALL_MASK = 16'hFFFF;

    acc_reg_if wr_bus ();

    // The bank forwards the host write path straight to the leaves.
    assign wr_bus.address      = reg_address;
    assign wr_bus.write_data   = reg_write_data;
    assign wr_bus.write_strobe = reg_write_strobe;

    logic [15:0] ch2_offset_cal_high_q;
    logic [15:0] ch2_offset_cal_low_q;
    logic [15:0] ch2_gain_cal_high_q;
    logic [15:0] ch2_gain_cal_low_q;
    logic [15:0] ch3_channel_config_q;
    logic [15:0] ch3_offset_cal_high_q;
    logic [15:0] ch3_offset_cal_low_q;

    // Channel 2 offset high word is kept so the 24-bit offset is whole.
    acc_word_reg #(.OFFSET(`ACC_OFF_CH2_OCAL_HIGH), .RST(`ACC_RST_ZERO), .WR_MASK(ALL_MASK)) u_ch2_oh (
        .clock   (clock),
        .reset   (reset),
        .bus     (wr_bus),
        .value_q (ch2_offset_cal_high_q)
    );
    // Channel 2 offset low word, byte 15:8 only.
    acc_word_reg #(.OFFSET(`ACC_OFF_CH2_OCAL_LOW), .RST(`ACC_RST_ZERO), .WR_MASK(LOW_MASK)) u_ch2_ol (
        .clock   (clock),
        .reset   (reset),
        .bus     (wr_bus),
        .value_q (ch2_offset_cal_low_q)
    );
    // Gain high resets to unity.
    acc_word_reg #(.OFFSET(`ACC_OFF_CH2_GCAL_HIGH), .RST(`ACC_RST_GAIN_HIGH), .WR_MASK(ALL_MASK)) u_ch2_gh (
        .clock   (clock),
        .reset   (reset),
        .bus     (wr_bus),
        .value_q (ch2_gain_cal_high_q)
    );
    acc_word_reg #(.OFFSET(`ACC_OFF_CH2_GCAL_LOW), .RST(`ACC_RST_ZERO), .WR_MASK(LOW_MASK)) u_ch2_gl (
        .clock   (clock),
        .reset   (reset),
        .bus     (wr_bus),
        .value_q (ch2_gain_cal_low_q)
    );
    // Config: bits 5:3 are masked off at the write.
    acc_word_reg #(.OFFSET(`ACC_OFF_CH3_CONFIG), .RST(`ACC_RST_ZERO), .WR_MASK(CFG_MASK)) u_ch3_channel_config (
        .clock   (clock),
        .reset   (reset),
        .bus     (wr_bus),
        .value_q (ch3_channel_config_q)
    );
    acc_word_reg #(.OFFSET(`ACC_OFF_CH3_OCAL_HIGH), .RST(`ACC_RST_ZERO), .WR_MASK(ALL_MASK)) u_ch3_oh (
        .clock   (clock),
        .reset   (reset),
        .bus     (wr_bus),
        .value_q (ch3_offset_cal_high_q)
    );
    acc_word_reg #(.OFFSET(`ACC_OFF_CH3_OCAL_LOW), .RST(`ACC_RST_ZERO), .WR_MASK(LOW_MASK)) u_ch3_ol (
        .clock   (clock),
        .reset   (reset),
        .bus     (wr_bus),
        .value_q (ch3_offset_cal_low_q)
    );

    // Staged 24-bit values assembled from high word and low byte.
    acc_cal_set_t staged_w;
    assign staged_w.chan2_offset = {ch2_offset_cal_high_q,
                                    ch2_offset_cal_low_q[`ACC_LOW_FIELD_MSB:`ACC_LOW_FIELD_LSB]};
    assign staged_w.chan2_gain   = {ch2_gain_cal_high_q,
                                    ch2_gain_cal_low_q[`ACC_LOW_FIELD_MSB:`ACC_LOW_FIELD_LSB]};
    assign staged_w.chan3_offset = {ch3_offset_cal_high_q,
                                    ch3_offset_cal_low_q[`ACC_LOW_FIELD_MSB:`ACC_LOW_FIELD_LSB]};
    assign staged_w.chan3_phase  = ch3_channel_config_q[`ACC_PHASE_MSB:`ACC_PHASE_LSB];
    assign staged_w.chan3_dc_off = ch3_channel_config_q[`ACC_DCOFF_BIT];
    assign staged_w.chan3_mux    = ch3_channel_config_q[`ACC_MUX_MSB:`ACC_MUX_LSB];

    // Any write to a mapped calibration word marks the staged set dirty.
    wire write_hit_w = reg_write_strobe &&
                       (reg_address >= `ACC_OFF_CH2_OCAL_HIGH) &&
                       (reg_address <= `ACC_OFF_CH3_OCAL_LOW);

    acc_cal_set_t applied_q;
    logic         pending_q;

    // The applied set changes only at a conversion boundary, so a half-written
    // high/low pair never reaches the datapath mid-conversion. A write in the
    // same cycle as a boundary is caught again at the next one.
    wire          pending_d = write_hit_w ? 1'b1 : (conversion_boundary ? 1'b0 : pending_q);
    acc_cal_set_t reset_set_w;
    assign reset_set_w = '{chan2_offset: 24'h000000, chan2_gain: {`ACC_RST_GAIN_HIGH, 8'h00},
                           chan3_offset: 24'h000000, chan3_phase: 10'h000, chan3_dc_off: 1'b0,
                           chan3_mux: 2'h0};

    always_ff @(posedge clock) begin
        if (reset) begin
            applied_q <= reset_set_w;
            pending_q <= 1'b0;
        end else begin
            if (conversion_boundary) begin
                applied_q <= staged_w;
            end
            pending_q <= pending_d;
        end
    end

    assign chan2_offset_trim = applied_q.chan2_offset;
    assign chan2_gain_trim   = applied_q.chan2_gain;
    assign chan3_offset_trim = applied_q.chan3_offset;
    assign chan3_phase_delay = applied_q.chan3_phase;
    assign update_pending    = pending_q;

    // DC filter runs only when the channel is not forced off and the global setting allows it.
    assign chan3_dc_filter_enable = global_dc_filter_setting && !applied_q.chan3_dc_off;

    // Input routing decode, exactly one selection active.
    acc_input_sel_t mux_w;
    assign mux_w               = acc_input_sel_t'(applied_q.chan3_mux);
    assign chan3_connect_pins  = (mux_w == ACC_IN_NORMAL);
    assign chan3_short_inputs  = (mux_w == ACC_IN_SHORTED);
    assign chan3_test_positive = (mux_w == ACC_IN_TEST_POS);
    assign chan3_test_negative = (mux_w == ACC_IN_TEST_NEG);

    // Read decode; unmapped addresses read as zero.
    logic [15:0] read_mux_w;
    always_comb begin
        if (reg_address == `ACC_OFF_CH2_OCAL_HIGH) begin
            read_mux_w = ch2_offset_cal_high_q;
        end else if (reg_address == `ACC_OFF_CH2_OCAL_LOW) begin
            read_mux_w = ch2_offset_cal_low_q;
        end else if (reg_address == `ACC_OFF_CH2_GCAL_HIGH) begin
            read_mux_w = ch2_gain_cal_high_q;
        end else if (reg_address == `ACC_OFF_CH2_GCAL_LOW) begin
            read_mux_w = ch2_gain_cal_low_q;
        end else if (reg_address == `ACC_OFF_CH3_CONFIG) begin
            read_mux_w = ch3_channel_config_q;
        end else if (reg_address == `ACC_OFF_CH3_OCAL_HIGH) begin
            read_mux_w = ch3_offset_cal_high_q;
        end else if (reg_address == `ACC_OFF_CH3_OCAL_LOW) begin
            read_mux_w = ch3_offset_cal_low_q;
        end else if (reg_address == `ACC_OFF_APPLY_STATUS) begin
            read_mux_w = {15'h0000, pending_q};
        end else begin
            read_mux_w = 16'h0000;
        end
    end

    // Read data is registered and stands for exactly the cycle after the strobe.
    always_ff @(posedge clock) begin
        if (reset) begin
            reg_read_data <= 16'h0000;
        end else begin
            reg_read_data <= reg_read_strobe ? read_mux_w : 16'h0000;
        end
    end
endmodule : acc_cal_regs

// ==== logic/acc_word_reg.sv ====
`include "acc_params.svh"

// One writable register with a mask of writable bits; masked bits stay zero.
module acc_word_reg #(
    parameter logic [5:0]  OFFSET   = 6'h00,
    parameter logic [15:0] RST      = 16'h0000,
    parameter logic [15:0] WR_MASK  = 16'hFFFF
) (
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        reset,
    // Write path.
    acc_reg_if.leaf          bus,
    // Stored value.
    output logic [15:0]      value_q
);
    wire         hit_w = bus.write_strobe && (bus.address == OFFSET);
    wire  [15:0] value_d = hit_w ? (bus.write_data & WR_MASK) : value_q;

    // Reserved bits are masked at the write, so they can never read back nonzero.
    always_ff @(posedge clock) begin
        if (reset) begin
            value_q <= RST;
        end else begin
            value_q <= value_d;
        end
    end
endmodule : acc_word_reg

// ==== test/acc_cal_regs_monitor.sv ====
// Watches the bank's host port and applied outputs.
module acc_cal_regs_monitor (
    // Clock and reset.
    input wire logic        clock,
    input wire logic        reset,
    // Host port.
    input wire logic [5:0]  reg_address,
    input wire logic        reg_write_strobe,
    input wire logic        reg_read_strobe,
    input wire logic [15:0] reg_read_data,
    // Datapath side.
    input wire logic        conversion_boundary,
    input wire logic        global_dc_filter_setting,
    input wire logic [23:0] chan2_offset_trim,
    input wire logic [23:0] chan2_gain_trim,
    input wire logic [23:0] chan3_offset_trim,
    input wire logic [9:0]  chan3_phase_delay,
    input wire logic        chan3_dc_filter_enable,
    input wire logic        chan3_short_inputs,
    input wire logic        chan3_connect_pins,
    input wire logic        chan3_test_positive,
    input wire logic        chan3_test_negative,
    input wire logic        update_pending
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // Read data only stands in the cycle after a read strobe.
    a_read_idle_zero: assert property (!reg_read_strobe |=> reg_read_data == 16'h0000)
        else $error("read data not zero outside a read");
    a_low_byte_zero: assert property (reg_read_strobe && reg_address inside {6'h15, 6'h17, 6'h1A}
        |=> reg_read_data[7:0] == 8'h00) else $error("low byte of a low word read nonzero");
    a_cfg_rsvd_zero: assert property (reg_read_strobe && reg_address == 6'h18
        |=> reg_read_data[5:3] == 3'h0) else $error("config reserved bits read nonzero");
    a_input_onehot: assert property ($onehot({chan3_test_negative, chan3_test_positive,
        chan3_short_inputs, chan3_connect_pins})) else $error("input routing not one-hot");
    // Routing must follow the applied set, so it may only switch at a conversion boundary.
    a_route_hold: assert property (!conversion_boundary |=>
        $stable({chan3_test_negative, chan3_test_positive, chan3_short_inputs, chan3_connect_pins}))
        else $error("input routing moved without a boundary");
    // Applied values may only move at a conversion boundary, so a half-written pair never leaks out mid-conversion.
    a_trim_hold: assert property (!conversion_boundary |=> $stable(chan2_offset_trim)
        && $stable(chan2_gain_trim) && $stable(chan3_offset_trim) && $stable(chan3_phase_delay))
        else $error("applied value moved without a boundary");
    a_reset_values: assert property ($fell(reset) |-> chan2_gain_trim == 24'h800000
        && chan3_offset_trim == 24'h000000 && chan3_connect_pins) else $error("bad value after reset");
    a_pending_set: assert property (reg_write_strobe && reg_address inside {[6'h14 : 6'h1A]}
        |=> update_pending) else $error("pending not set by a write");
    a_pending_clear: assert property (conversion_boundary && !reg_write_strobe
        |=> !update_pending) else $error("pending not cleared by a boundary");
    a_dc_global: assert property (!global_dc_filter_setting |-> !chan3_dc_filter_enable)
        else $error("DC filter on while the global setting is off");
endmodule : acc_cal_regs_monitor

bind acc_cal_regs acc_cal_regs_monitor acc_cal_regs_monitor_i (.clock, .reset, .reg_address,
    .reg_write_strobe, .reg_read_strobe, .reg_read_data, .conversion_boundary, .global_dc_filter_setting,
    .chan2_offset_trim, .chan2_gain_trim, .chan3_offset_trim, .chan3_phase_delay, .chan3_dc_filter_enable,
    .chan3_short_inputs, .chan3_connect_pins, .chan3_test_positive, .chan3_test_negative, .update_pending);

// ==== test/tb_acc_cal_regs.sv ====
// Self-checking bench: a driver queues read expectations, a monitor pops and compares them.
module tb_acc_cal_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 0, reset = 1, reg_write_strobe = 0, reg_read_strobe = 0, rd_seen = 0;
    logic        conversion_boundary = 0, global_dc_filter_setting = 0, pend, g;
    logic        c3_dc, c3_short, c3_pins, c3_pos, c3_neg;
    logic [5:0]  reg_address = 0;
    logic [15:0] reg_write_data = 0, reg_read_data, d, r, val [8], exp_q [$];
    logic [23:0] c2_off, c2_gain, c3_off;
    logic [9:0]  c3_phase;
    logic [31:0] seed = 1592;
    int          n_fail = 0, n_tests = 0, cycles = 0;
    // Register index table: mapped words 14h..1Ah, then one unmapped place.
    logic [5:0]  adr [8] = '{6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1A, 6'h20};
    logic [15:0] msk [8] = '{16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00, 16'hFFC7, 16'hFFFF, 16'hFF00, 16'h0000};

    acc_cal_regs acc_cal_regs_i (.clock, .reset, .reg_address, .reg_write_data, .reg_write_strobe,
        .reg_read_strobe, .reg_read_data, .conversion_boundary, .global_dc_filter_setting,
        .chan2_offset_trim(c2_off), .chan2_gain_trim(c2_gain), .chan3_offset_trim(c3_off),
        .chan3_phase_delay(c3_phase), .chan3_dc_filter_enable(c3_dc), .chan3_short_inputs(c3_short),
        .chan3_connect_pins(c3_pins), .chan3_test_positive(c3_pos), .chan3_test_negative(c3_neg),
        .update_pending(pend));

    // Free-running clock, 50 ns period.
    initial begin
        forever #25 clock = ~clock;
    end

    function automatic logic [15:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : xs

    task automatic compare(logic [23:0] got, logic [23:0] exp, string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : compare

    // Read data gets its own compare so the 16-bit word is checked at its true width.
    task automatic compare_read(logic [15:0] got, logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: read got %h expected %h", $time, got, exp);
        end
    endtask : compare_read

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict

    // Every host-port input and the boundary are assigned exactly once per cycle, so back-to-back calls never collide.
    task automatic cyc(logic w, logic rs, logic [5:0] a, logic [15:0] wd, logic b);
        reg_write_strobe <= w;
        reg_read_strobe <= rs;
        reg_address <= a;
        reg_write_data <= wd;
        conversion_boundary <= b;
        @(posedge clock);
    endtask : cyc

    task automatic rd(logic [5:0] a, logic [15:0] e);
        exp_q.push_back(e);
        cyc(0, 1, a, 16'h0000, 0);
    endtask : rd

    // Read data is sampled mid-cycle after the strobe, where it has settled.
    always @(posedge clock) rd_seen <= reg_read_strobe;
    always @(negedge clock) begin
        if (rd_seen === 1'b1) compare_read(reg_read_data, exp_q.pop_front());
    end

    // Hang guard; the whole run needs well under a hundred cycles.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            n_fail++;
            print_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge clock);
        reset <= 0;
        for (int i = 0; i < 8; i++) rd(adr[i], (i == 2) ? 16'h8000 : 16'h0000);
        compare(c2_gain, 24'h800000, "gain after reset");
        compare({c3_neg, c3_pos, c3_short, c3_pins, pend}, 24'h2, "routing after reset");
        for (int i = 0; i < 8; i++) begin
            d = xs();
            val[i] = d & msk[i];
            cyc(1, 0, adr[i], d, 0);
            rd(adr[i], val[i]);
        end
        compare(pend, 1, "pending after writes");
        rd(6'h3F, 16'h0001);
        compare(c2_gain, 24'h800000, "gain before boundary");
        cyc(0, 0, 6'h00, 16'h0000, 1);
        cyc(0, 0, 6'h00, 16'h0000, 0);
        compare(c2_off, {val[0], val[1][15:8]}, "chan2 offset");
        compare(c2_gain, {val[2], val[3][15:8]}, "chan2 gain");
        compare(c3_off, {val[5], val[6][15:8]}, "chan3 offset");
        compare(c3_phase, val[4][15:6], "chan3 phase");
        compare(pend, 0, "pending after boundary");
        rd(6'h3F, 16'h0000);
        // Every routing code with the filter-off bit both ways, global setting random.
        for (int k = 0; k < 8; k++) begin
            r = xs();
            d = {r[15:3], k[2:0]};
            g = r[3];
            global_dc_filter_setting <= g;
            cyc(1, 0, 6'h18, d, 0);
            cyc(0, 0, 6'h00, 16'h0000, 1);
            cyc(0, 0, 6'h00, 16'h0000, 0);
            compare(c3_dc, g & ~d[2], "dc filter enable");
            compare({c3_neg, c3_pos, c3_short, c3_pins}, 4'h1 << d[1:0], "input routing");
            compare(c3_phase, d[15:6], "phase field");
        end
        // A write in the boundary cycle misses that boundary and keeps the update pending.
        cyc(1, 0, 6'h19, 16'h00AA, 1);
        cyc(0, 0, 6'h00, 16'h0000, 0);
        compare(pend, 1, "pending kept");
        compare(c3_off, {val[5], val[6][15:8]}, "offset before copy");
        cyc(0, 0, 6'h00, 16'h0000, 1);
        cyc(0, 0, 6'h00, 16'h0000, 0);
        compare(c3_off, {16'h00AA, val[6][15:8]}, "offset after copy");
        cyc(0, 0, 6'h00, 16'h0000, 0);
        print_verdict();
    end
endmodule : tb_acc_cal_regs
